// ---- core/sst_defs.svh ----
`ifndef SST_DEFS_SVH
`define SST_DEFS_SVH

// ==========================================================
// register byte offsets
`define SST_REG_CTRL 8'h00
`define SST_REG_INSTR 8'h04
`define SST_REG_STATUS 8'h08
`define SST_REG_FLAGS 8'h0C
`define SST_REG_ACC 8'h10
`define SST_REG_BANK 8'h14
`define SST_REG_PTR 8'h18
`define SST_REG_LATCH 8'h1C
`define SST_REG_INDEX 8'h20
`define SST_REG_DM_ADDR 8'h24
`define SST_REG_DM_DATA 8'h28
`define SST_REG_PM_ADDR 8'h2C
`define SST_REG_PM_DATA 8'h30

// ==========================================================
// field positions
`define SST_CTRL_EXT 0
`define SST_STAT_BUSY 0
`define SST_STAT_ILLEGAL 1
`define SST_FLG_C 0
`define SST_FLG_DC 1
`define SST_FLG_Z 2
`define SST_FLG_OV 3
`define SST_FLG_N 4
`define SST_INSTR_DEST 9
`define SST_INSTR_ACCESS 8

// ==========================================================
// opcode patterns
`define SST_OPC_SUB 6'h16
`define SST_OPC_SWAP 6'h0E
`define SST_OPC_TBL 14'h0002

// ==========================================================
// addressing limits and reset values
`define SST_ACCESS_SPLIT 8'h60
`define SST_INDEXED_MAX 8'h5F
`define SST_ACCESS_HI_BANK 4'hF
`define SST_RST_BYTE 8'h00
`define SST_RST_PTR 21'h000000
`define SST_RST_WORD 32'h00000000

`endif

// ---- core/sst_pkg.sv ----
package sst_pkg;

  // ==========================================================
  // decoded operation
  typedef enum logic [1:0] {OP_NONE, OP_SUB, OP_SWAP, OP_TBL} sst_op_t;

  // ==========================================================
  // quarter phases of the first and the second instruction cycle
  typedef enum logic [3:0] {
    ST_IDLE, ST_Q1, ST_Q2, ST_Q3, ST_Q4, ST_T1, ST_T2, ST_T3, ST_T4
  } sst_state_t;

  // ==========================================================
  // pointer update modes of the table read
  typedef enum logic [1:0] {
    TM_KEEP, TM_POST_INC, TM_POST_DEC, TM_PRE_INC
  } sst_tmode_t;

endpackage : sst_pkg

// ---- core/sst_alu.sv ----
`include "sst_defs.svh"

module sst_alu
(
  // operation and operands
  input wire sst_pkg::sst_op_t op,
  input wire logic [7:0] operand,
  input wire logic [7:0] acc,
  input wire logic [4:0] flags_in,
  // outcome
  output logic [7:0] result,
  output logic [4:0] flags_out
);
  import sst_pkg::*;

  logic [8:0] sum;
  logic [4:0] low;

  // file minus accumulator minus inverted carry, as file + ~acc + carry
  always_comb
  begin
    sum = {1'b0, operand} + {1'b0, ~acc} + {8'h00, flags_in[`SST_FLG_C]};
    low = {1'b0, operand[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, flags_in[`SST_FLG_C]};
    result = operand;
    flags_out = flags_in;
    case (op)
      OP_SUB:
      begin
        result = sum[7:0];
        flags_out[`SST_FLG_C] = sum[8];
        flags_out[`SST_FLG_DC] = low[4];
        flags_out[`SST_FLG_Z] = (sum[7:0] == 8'h00);
        flags_out[`SST_FLG_OV] = (operand[7] != acc[7]) && (sum[7] != operand[7]);
        flags_out[`SST_FLG_N] = sum[7];
      end
      OP_SWAP:
      begin
        result = {operand[3:0], operand[7:4]};
      end
      default:
      begin
        result = operand;
      end
    endcase
  end

endmodule : sst_alu

// ---- core/sst_prog_mem.sv ----
`include "sst_defs.svh"

module sst_prog_mem
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // loading port
  input wire logic wr_en,
  input wire logic [9:0] wr_addr,
  input wire logic [15:0] wr_data,
  // fetch port
  input wire logic rd_en,
  input wire logic [9:0] rd_addr,
  output logic [15:0] rd_data
);
  import sst_pkg::*;

  typedef struct packed {
    logic [15:0] rd_data;
  } sst_pm_state_t;

  logic [15:0] words [0:1023];
  sst_pm_state_t s_q;
  sst_pm_state_t s_d;

  // program word store
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      words[wr_addr] <= wr_data;
    end
  end

  // registered fetch
  always_comb
  begin
    s_d = s_q;
    if (rd_en)
    begin
      s_d.rd_data = words[rd_addr];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.rd_data;

endmodule : sst_prog_mem

// ---- core/sst_core.sv ----
// Notes on behaviour
// - file minus acc minus not-carry, five flags
// - upper bits 010110 select borrow subtract
// - upper bits 001110 swap nibbles, flags kept
// - swap takes one word, one cycle
// - pattern 0000 0000 0000 10nn is table read
// - mode 0 loads latch, pointer kept
// - post-increment loads then adds one
// - post-decrement loads then subtracts one
// - pre-increment adds one then loads
// - 21-bit byte pointer, table read keeps flags
// - pointer bit zero selects byte
// - destination bit chooses accumulator or file
// - access bit chooses access bank or bank
// - extended set, low addresses use index offset
// - second cycle reads memory, writes latch
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`include "sst_defs.svh"

module sst_core
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import sst_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    sst_state_t st;
    sst_op_t op;
    logic [15:0] instr;
    logic ext_en;
    logic illegal;
    logic [7:0] acc;
    logic [3:0] bank;
    logic [4:0] flags;
    logic [20:0] ptr;
    logic [7:0] latch;
    logic [11:0] index;
    logic [11:0] dm_addr;
    logic [9:0] pm_addr;
    logic [7:0] operand;
    logic [11:0] eff;
    logic [7:0] result;
    logic [4:0] new_flags;
    logic ack;
    logic [31:0] rdata;
  } sst_core_state_t;

  sst_core_state_t s_q;
  sst_core_state_t s_d;
  logic [7:0] dmem [0:4095];
  logic dm_we;
  logic [11:0] dm_wa;
  logic [7:0] dm_wd;
  logic pm_we;
  logic pm_re;
  logic [15:0] pm_rdata;
  logic [7:0] alu_result;
  logic [4:0] alu_flags;
  logic req;
  logic wr_go;
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  logic [31:0] wmerge;

  // ==========================================================
  // functions

  // merge written bytes under the byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // effective data address of a file operand
  function automatic logic [11:0] eff_addr(input logic [7:0] f,
                                          input logic acc_bit,
                                          input logic [3:0] bank,
                                          input logic ext,
                                          input logic [11:0] index);
    logic [11:0] r;
    if (acc_bit)
    begin
      r = {bank, f};
    end
    else if (ext && (f <= `SST_INDEXED_MAX))
    begin
      r = index + {4'h0, f};
    end
    else if (f < `SST_ACCESS_SPLIT)
    begin
      r = {4'h0, f};
    end
    else
    begin
      r = {`SST_ACCESS_HI_BANK, f};
    end
    return r;
  endfunction : eff_addr

  // decode of a 16-bit instruction word
  function automatic sst_op_t decode(input logic [15:0] w);
    sst_op_t r;
    r = OP_NONE;
    if (w[15:10] == `SST_OPC_SUB)
    begin
      r = OP_SUB;
    end
    else if (w[15:10] == `SST_OPC_SWAP)
    begin
      r = OP_SWAP;
    end
    else if (w[15:2] == `SST_OPC_TBL)
    begin
      r = OP_TBL;
    end
    return r;
  endfunction : decode

  // ==========================================================
  // submodules
  sst_alu u_alu
  (
    .op(s_q.op),
    .operand(s_q.operand),
    .acc(s_q.acc),
    .flags_in(s_q.flags),
    .result(alu_result),
    .flags_out(alu_flags)
  );

  sst_prog_mem u_pmem
  (
    .clk(clk),
    .reset(reset),
    .wr_en(pm_we),
    .wr_addr(s_q.pm_addr),
    .wr_data(avs_writedata[15:0]),
    .rd_en(pm_re),
    .rd_addr(s_q.ptr[10:1]),
    .rd_data(pm_rdata)
  );

  // ==========================================================
  // bus handshake: answer one cycle after a request, stall while busy
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~s_q.ack;
  assign wr_go = avs_write & s_q.ack;
  assign avs_readdata = s_q.rdata;
  // write word merged into the addressed register under the byte enables
  assign wmerge = be_merge(rd_mux, avs_writedata, avs_byteenable);
  assign pm_we = wr_go && (avs_address == `SST_REG_PM_DATA) && avs_byteenable[0];
  assign pm_re = (s_q.st == ST_T2);

  // status view
  always_comb
  begin
    status_word = `SST_RST_WORD;
    status_word[`SST_STAT_BUSY] = (s_q.st != ST_IDLE);
    status_word[`SST_STAT_ILLEGAL] = s_q.illegal;
  end

  // read data selection
  always_comb
  begin
    case (avs_address)
      `SST_REG_CTRL: rd_mux = {31'h0, s_q.ext_en};
      `SST_REG_INSTR: rd_mux = {16'h0, s_q.instr};
      `SST_REG_STATUS: rd_mux = status_word;
      `SST_REG_FLAGS: rd_mux = {27'h0, s_q.flags};
      `SST_REG_ACC: rd_mux = {24'h0, s_q.acc};
      `SST_REG_BANK: rd_mux = {28'h0, s_q.bank};
      `SST_REG_PTR: rd_mux = {11'h0, s_q.ptr};
      `SST_REG_LATCH: rd_mux = {24'h0, s_q.latch};
      `SST_REG_INDEX: rd_mux = {20'h0, s_q.index};
      `SST_REG_DM_ADDR: rd_mux = {20'h0, s_q.dm_addr};
      `SST_REG_DM_DATA: rd_mux = {24'h0, dmem[s_q.dm_addr]};
      `SST_REG_PM_ADDR: rd_mux = {22'h0, s_q.pm_addr};
      `SST_REG_PM_DATA: rd_mux = {16'h0, pm_rdata};
      default: rd_mux = `SST_RST_WORD;
    endcase
  end

  // data memory write port: execution result or bus
  always_comb
  begin
    dm_we = 1'b0;
    dm_wa = s_q.dm_addr;
    dm_wd = avs_writedata[7:0];
    if ((s_q.st == ST_Q4) && (s_q.op != OP_TBL) && s_q.instr[`SST_INSTR_DEST])
    begin
      dm_we = 1'b1;
      dm_wa = s_q.eff;
      dm_wd = s_q.result;
    end
    else if (wr_go && (avs_address == `SST_REG_DM_DATA) && avs_byteenable[0])
    begin
      dm_we = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (dm_we)
    begin
      dmem[dm_wa] <= dm_wd;
    end
  end

  // ==========================================================
  // next state: bus registers and instruction sequencer
  always_comb
  begin
    s_d = s_q;
    s_d.ack = req & ~s_q.ack & (s_q.st == ST_IDLE);
    if (s_d.ack)
    begin
      s_d.rdata = rd_mux;
    end
    if (wr_go)
    begin
      case (avs_address)
        `SST_REG_CTRL: s_d.ext_en = wmerge[0];
        `SST_REG_FLAGS: s_d.flags = wmerge[4:0];
        `SST_REG_ACC: s_d.acc = wmerge[7:0];
        `SST_REG_BANK: s_d.bank = wmerge[3:0];
        `SST_REG_PTR: s_d.ptr = wmerge[20:0];
        `SST_REG_LATCH: s_d.latch = wmerge[7:0];
        `SST_REG_INDEX: s_d.index = wmerge[11:0];
        `SST_REG_DM_ADDR: s_d.dm_addr = wmerge[11:0];
        `SST_REG_PM_ADDR: s_d.pm_addr = wmerge[9:0];
        `SST_REG_STATUS:
        begin
          if (avs_byteenable[0] && avs_writedata[`SST_STAT_ILLEGAL])
          begin
            s_d.illegal = 1'b0;
          end
        end
        `SST_REG_INSTR:
        begin
          s_d.instr = wmerge[15:0];
          s_d.st = ST_Q1;
        end
        default:
        begin
          s_d.rdata = s_q.rdata;
        end
      endcase
    end
    case (s_q.st)
      ST_IDLE:
      begin
        s_d.op = s_q.op;
      end
      ST_Q1:
      begin
        s_d.op = decode(s_q.instr);
        s_d.eff = eff_addr(s_q.instr[7:0], s_q.instr[`SST_INSTR_ACCESS], s_q.bank,
                           s_q.ext_en, s_q.index);
        if (decode(s_q.instr) == OP_NONE)
        begin
          s_d.illegal = 1'b1;
          s_d.st = ST_IDLE;
        end
        else
        begin
          s_d.st = ST_Q2;
        end
      end
      ST_Q2:
      begin
        s_d.operand = dmem[s_q.eff];
        s_d.st = ST_Q3;
      end
      ST_Q3:
      begin
        s_d.result = alu_result;
        s_d.new_flags = alu_flags;
        s_d.st = ST_Q4;
      end
      ST_Q4:
      begin
        s_d.st = ST_IDLE;
        if (s_q.op == OP_TBL)
        begin
          s_d.st = ST_T1;
          if (s_q.instr[1:0] == TM_PRE_INC)
          begin
            s_d.ptr = s_q.ptr + 21'h000001;
          end
        end
        else
        begin
          // destination bit zero goes to accumulator
          if (!s_q.instr[`SST_INSTR_DEST])
          begin
            s_d.acc = s_q.result;
          end
          s_d.flags = s_q.new_flags;
        end
      end
      ST_T1:
      begin
        s_d.st = ST_T2;
      end
      ST_T2:
      begin
        s_d.st = ST_T3;
      end
      ST_T3:
      begin
        s_d.st = ST_T4;
      end
      ST_T4:
      begin
        s_d.st = ST_IDLE;
        s_d.latch = s_q.ptr[0] ? pm_rdata[15:8] : pm_rdata[7:0];
        if (s_q.instr[1:0] == TM_POST_INC)
        begin
          s_d.ptr = s_q.ptr + 21'h000001;
        end
        else if (s_q.instr[1:0] == TM_POST_DEC)
        begin
          s_d.ptr = s_q.ptr - 21'h000001;
        end
      end
      default:
      begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_sub_to_acc: assert property (
    (s_q.st == ST_Q4 && s_q.op == OP_SUB && !s_q.instr[9])
    |=> s_q.acc == 8'($past(s_q.operand) - $past(s_q.acc) - {7'h0, !$past(s_q.flags[0])})
    && s_q.flags[2] == (s_q.acc == 8'h00) && s_q.flags[4] == s_q.acc[7])
    else $error("borrow subtract result or flags wrong");
  chk_sub_decode: assert property (
    (s_q.st == ST_Q1 && s_q.instr[15:10] == 6'h16) |=> s_q.op == OP_SUB)
    else $error("borrow subtract not decoded");
  chk_swap_write: assert property (
    (s_q.st == ST_Q4 && s_q.op == OP_SWAP && s_q.instr[9])
    |=> dmem[s_q.eff] == {s_q.operand[3:0], s_q.operand[7:4]} && $stable(s_q.flags))
    else $error("nibble swap wrong or flags moved");
  chk_swap_one_cycle: assert property (
    (s_q.st == ST_Q2 && s_q.op == OP_SWAP) |-> ##3 s_q.st == ST_IDLE)
    else $error("nibble swap exceeds one instruction cycle");
  chk_tbl_decode: assert property (
    (s_q.st == ST_Q1 && s_q.instr[15:2] == 14'h0002) |=> s_q.op == OP_TBL ##3 s_q.st == ST_T1)
    else $error("table read not decoded");
  chk_tbl_keep_ptr: assert property (
    (s_q.st == ST_Q2 && s_q.op == OP_TBL && s_q.instr[1:0] == 2'h0)
    |-> ##7 $stable(s_q.ptr) && s_q.st == ST_IDLE)
    else $error("mode zero moved pointer");
  chk_tbl_post_step: assert property (
    (s_q.st == ST_T4 && s_q.instr[1] == 1'b0 && s_q.instr[0])
    |=> s_q.ptr == 21'($past(s_q.ptr) + 21'h1) && s_q.latch == ($past(s_q.ptr[0]) ?
    $past(pm_rdata[15:8]) : $past(pm_rdata[7:0])))
    else $error("post-increment wrong");
  chk_tbl_post_dec: assert property (
    (s_q.st == ST_T4 && s_q.instr[1:0] == 2'h2) |=> s_q.ptr == 21'($past(s_q.ptr) - 21'h1))
    else $error("post-decrement wrong");
  chk_tbl_pre_inc: assert property (
    (s_q.st == ST_Q4 && s_q.op == OP_TBL && s_q.instr[1:0] == 2'h3)
    |=> s_q.ptr == 21'($past(s_q.ptr) + 21'h1) ##4 $stable(s_q.ptr))
    else $error("pre-increment wrong");
  chk_tbl_flags: assert property (
    (s_q.st == ST_T1) |-> ##4 $stable(s_q.flags))
    else $error("table read changed flags");
  chk_access_bank: assert property (
    (s_q.st == ST_Q1 && !s_q.instr[8] && !s_q.ext_en)
    |=> s_q.eff[11:8] == ((s_q.instr[7:0] < 8'h60) ? 4'h0 : 4'hF))
    else $error("access bank address wrong");

  cov_sub_run: cover property (s_q.st == ST_Q4 && s_q.op == OP_SUB);
  cov_swap_run: cover property (s_q.st == ST_Q4 && s_q.op == OP_SWAP);
  cov_tbl_pre: cover property (s_q.st == ST_T4 && s_q.instr[1:0] == 2'h3);
  cov_ptr_wrap: cover property (s_q.st == ST_T4 && s_q.ptr == 21'h1FFFFF);

endmodule : sst_core

// ---- testbench/sst_host_model.sv ----
module sst_host_model
(
  // clock
  input wire logic clk,
  // avalon-mm master side
  output logic [7:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // idle bus at time zero
  initial
  begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    byteenable = 4'hF;
  end

  // one transfer: hold the request until waitrequest is seen low
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    address <= a;
    read <= ~w;
    write <= w;
    writedata <= d;
    // look at each rising edge; the request stands until waitrequest is low there
    forever
    begin
      @(posedge clk);
      if (waitrequest === 1'b0)
        break;
    end
    // read data taken at the accepting edge, request dropped right after it
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : xfer
endmodule : sst_host_model

// ---- testbench/subtract_swap_table_read_exec_test.sv ----
`include "sst_defs.svh"

module subtract_swap_table_read_exec_test;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // clock, reset and bus
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  logic [31:0] readdata;
  logic waitrequest;
  int num_errors = 0;
  int checks_done = 0;

  always #12.5 clk = ~clk;

  sst_core dut (.clk(clk), .reset(reset), .avs_address(address), .avs_read(read),
    .avs_write(write), .avs_writedata(writedata), .avs_byteenable(byteenable),
    .avs_readdata(readdata), .avs_waitrequest(waitrequest));

  sst_host_model m (.clk(clk), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest));

  // ==========================================================
  // shared helpers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    m.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    m.xfer(1'b0, a, 32'h00000000, q);
  endtask : rd

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", what, e, g);
    end
  endtask : chk

  task automatic chk_reg(input string what, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    rd(a, q);
    chk(what, e, q);
  endtask : chk_reg

  // reference borrow subtract: {N, OV, Z, DC, C, result}
  function automatic logic [12:0] sub_ref(logic [7:0] f, logic [7:0] w, logic c);
    logic [8:0] r;
    logic [4:0] l;
    r = {1'b0, f} - {1'b0, w} - {8'h00, ~c};
    l = {1'b0, f[3:0]} - {1'b0, w[3:0]} - {4'h0, ~c};
    return {r[7], (f[7] != w[7]) && (r[7] != f[7]), r[7:0] == 8'h00, ~l[4], ~r[8], r[7:0]};
  endfunction : sub_ref

  // ==========================================================
  // scenarios
  task automatic test_reset;
    chk_reg("flags", `SST_REG_FLAGS, 32'h00000000);
    chk_reg("acc", `SST_REG_ACC, 32'h00000000);
    chk_reg("pointer", `SST_REG_PTR, 32'h00000000);
    chk_reg("latch", `SST_REG_LATCH, 32'h00000000);
    chk_reg("unmapped", 8'h40, 32'h00000000);
  endtask : test_reset

  task automatic run_sub(input logic [7:0] f, input logic [7:0] w, input logic c,
                         input logic d, input logic a, input logic [3:0] bank);
    logic [11:0] da;
    logic [12:0] e;
    da = a ? {bank, f} : {(f < 8'h60) ? 4'h0 : 4'hF, f};
    e = sub_ref(f, w, c);
    wr(`SST_REG_BANK, {28'h0000000, bank});
    wr(`SST_REG_DM_ADDR, {20'h00000, da});
    wr(`SST_REG_DM_DATA, {24'h000000, f});
    wr(`SST_REG_ACC, {24'h000000, w});
    wr(`SST_REG_FLAGS, {31'h00000000, c});
    wr(`SST_REG_INSTR, {16'h0000, `SST_OPC_SUB, d, a, f});
    chk_reg("sub dest", d ? `SST_REG_DM_DATA : `SST_REG_ACC, {24'h000000, e[7:0]});
    chk_reg("sub flags", `SST_REG_FLAGS, {27'h0000000, e[12:8]});
    if (!d)
      chk_reg("sub file kept", `SST_REG_DM_DATA, {24'h000000, f});
  endtask : run_sub

  task automatic test_swap;
    wr(`SST_REG_CTRL, 32'h00000001);
    wr(`SST_REG_INDEX, 32'h00000200);
    wr(`SST_REG_DM_ADDR, 32'h00000210);
    wr(`SST_REG_DM_DATA, 32'h00000053);
    wr(`SST_REG_FLAGS, 32'h0000001F);
    wr(`SST_REG_INSTR, {16'h0000, `SST_OPC_SWAP, 1'b1, 1'b0, 8'h10});
    chk_reg("swap file", `SST_REG_DM_DATA, 32'h00000035);
    chk_reg("swap flags", `SST_REG_FLAGS, 32'h0000001F);
    wr(`SST_REG_INSTR, {16'h0000, `SST_OPC_SWAP, 1'b0, 1'b0, 8'h10});
    chk_reg("swap acc", `SST_REG_ACC, 32'h00000053);
    chk_reg("swap file kept", `SST_REG_DM_DATA, 32'h00000035);
    wr(`SST_REG_CTRL, 32'h00000000);
  endtask : test_swap

  task automatic run_tbl(input logic [1:0] mode, input logic [20:0] p,
                         input logic [7:0] e_lat, input logic [20:0] e_ptr);
    wr(`SST_REG_PTR, {11'h000, p});
    wr(`SST_REG_INSTR, {16'h0000, `SST_OPC_TBL, mode});
    chk_reg("table latch", `SST_REG_LATCH, {24'h000000, e_lat});
    chk_reg("table pointer", `SST_REG_PTR, {11'h000, e_ptr});
  endtask : run_tbl

  task automatic test_tbl;
    wr(`SST_REG_PM_ADDR, 32'h00000000);
    wr(`SST_REG_PM_DATA, 32'h00001234);
    wr(`SST_REG_PM_ADDR, 32'h00000001);
    wr(`SST_REG_PM_DATA, 32'h00005678);
    wr(`SST_REG_FLAGS, 32'h00000015);
    run_tbl(2'd0, 21'h000001, 8'h12, 21'h000001);
    run_tbl(2'd1, 21'h000001, 8'h12, 21'h000002);
    run_tbl(2'd2, 21'h000000, 8'h34, 21'h1FFFFF);
    run_tbl(2'd3, 21'h1FFFFF, 8'h34, 21'h000000);
    run_tbl(2'd3, 21'h000002, 8'h56, 21'h000003);
    chk_reg("table flags", `SST_REG_FLAGS, 32'h00000015);
  endtask : test_tbl

  task automatic test_illegal;
    wr(`SST_REG_ACC, 32'h000000A5);
    wr(`SST_REG_INSTR, 32'h0000FFFF);
    chk_reg("illegal set", `SST_REG_STATUS, 32'h00000002);
    chk_reg("illegal acc", `SST_REG_ACC, 32'h000000A5);
    wr(`SST_REG_STATUS, 32'h00000002);
    chk_reg("illegal clear", `SST_REG_STATUS, 32'h00000000);
  endtask : test_illegal

  // ==========================================================
  // verdict
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    test_reset();
    run_sub(8'h19, 8'h0D, 1'b1, 1'b1, 1'b1, 4'h3);
    run_sub(8'h1B, 8'h1A, 1'b0, 1'b0, 1'b0, 4'h3);
    run_sub(8'h03, 8'h0E, 1'b1, 1'b1, 1'b0, 4'h0);
    run_sub(8'h80, 8'h01, 1'b1, 1'b1, 1'b0, 4'h2);
    run_sub(8'h70, 8'h08, 1'b0, 1'b1, 1'b0, 4'h2);
    test_swap();
    test_tbl();
    test_illegal();
    finish_test();
  end

  // watchdog well beyond the few hundred cycles of the sequence
  initial
  begin
    #500000;
    num_errors++;
    finish_test();
  end
endmodule : subtract_swap_table_read_exec_test
